// ### include/adc_port_defs.vh
`ifndef ADC_PORT_DEFS_VH
`define ADC_PORT_DEFS_VH

// Serial word layout
`define WORD_BITS      16
`define LEAD_ZEROS     4
`define LEAD_POS       5'h04
`define POS_W          5
`define POS_LAST       5'h10

// Converter core width and variant
`define CORE_BITS      12
`define RES_12         12
`define RES_10         10
`define RES_8          8

// Sample buffer
`define FIFO_DEPTH     16
`define FIFO_AW        4

// Reset values
`define TRACK_RST      1'b1
`define OE_RST         1'b0

`endif

// ### verilog/sample_fifo.v
`timescale 1ns/10ps
module sample_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             rst,
  // Fill side
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  // Drain side
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;

  // Full and empty come straight from the occupancy count
  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage, no reset needed on the array
  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap naturally since DEPTH is a power of two
  always @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      case ({push, pop})
        2'b10:   count_r <= count_r + 1'b1;
        2'b01:   count_r <= count_r - 1'b1;
        default: count_r <= count_r;
      endcase
    end
  end

endmodule // sample_fifo

// ### verilog/serial_adc_readout_port.v
// Function
// - Serial output moves to the next word bit on each serial clock falling edge.
// - 12-bit variant sends four zeros then twelve result bits, MSB first.
// - 10-bit variant sends four zeros, ten result bits MSB first, two zeros.
// - 8-bit variant sends four zeros, eight result bits MSB first, four zeros.
// - Active-low select; its falling edge starts a conversion.
// - The asserted select interval frames exactly one result word.
// - Conversion steps are paced by the controller's serial clock only.
// - After conversion ends, the sampling stage returns to tracking.
// - Each frame carries one sixteen-bit word; controller clocks all sixteen.
`timescale 1ns/10ps
`include "adc_port_defs.vh"
module serial_adc_readout_port #(
  parameter RES_BITS = `RES_12
) (
  // Clock and reset
  input  wire                  core_clk,
  input  wire                  rst,
  // Serial link pins
  input  wire                  sclk,
  input  wire                  cs_n,
  output reg                   result_serial_out,
  output reg                   result_serial_oe,
  // Digitised analog input samples
  input  wire [`CORE_BITS-1:0] analog_in,
  input  wire                  analog_in_valid,
  output wire                  analog_in_ready,
  // Status
  output reg                   tracking
);

  // Frame states, one-hot
  localparam ST_IDLE  = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_DONE  = 3'b100;

  reg [2:0]            state_r;
  reg [2:0]            state_nxt;
  reg [`POS_W-1:0]     pos_r;
  reg [`POS_W-1:0]     pos_nxt;
  reg [`CORE_BITS-1:0] held_r;
  reg [`CORE_BITS-1:0] sar_r;
  reg [`CORE_BITS-1:0] sar_nxt;
  reg                  sclk_s1_r;
  reg                  sclk_s2_r;
  reg                  sclk_s3_r;
  reg                  cs_s1_r;
  reg                  cs_s2_r;
  reg                  cs_s3_r;
  reg                  dout_nxt;
  reg                  oe_nxt;
  reg                  track_nxt;
  wire                 sclk_fall;
  wire                 cs_fall;
  wire                 cs_high;
  wire [`CORE_BITS-1:0] fifo_data;
  wire                 fifo_valid;
  wire [`POS_W-1:0]    res_end;
  wire                 frame_start;

  // Position just past the last result bit, cut to the position width
  localparam [31:0] RES_END_W = `LEAD_ZEROS + RES_BITS;
  assign res_end = RES_END_W[`POS_W-1:0];

  // Trial weight for result bit k, MSB first, aligned to the core top
  function [`CORE_BITS-1:0] trial_bit;
    input [`POS_W-1:0] k;
    begin
      trial_bit = {{(`CORE_BITS-1){1'b0}}, 1'b1} << (`CORE_BITS - 1 - k);
    end
  endfunction

  // Result bit index of a word position; only called inside the result span
  function [`POS_W-1:0] res_index;
    input [`POS_W-1:0] p;
    begin
      res_index = p - `LEAD_POS;
    end
  endfunction

  // Serial clock pin is from the controller's domain: two flops, a third for edges
  always @(posedge core_clk) begin
    if (rst) begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
    end else begin
      sclk_s1_r <= sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
    end
  end

  // Select syncs reset high, its idle level, so no false start follows reset
  always @(posedge core_clk) begin
    if (rst) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
    end else begin
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
    end
  end

  // Edge detectors look only at the second and third stages
  assign sclk_fall = sclk_s3_r & ~sclk_s2_r;
  assign cs_fall   = cs_s3_r & ~cs_s2_r;
  assign cs_high   = cs_s2_r;

  // Pop and capture share one strobe, so a word is never popped unused
  assign frame_start = cs_fall & (state_r == ST_IDLE);

  // Sample buffer; drained only by a new frame, so it fills between frames
  // An empty buffer leaves the old sample held: the controller never stalls
  sample_fifo #(
    .WIDTH (`CORE_BITS),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_data   (analog_in),
    .in_valid  (analog_in_valid),
    .in_ready  (analog_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (frame_start)
  );

  // Frame sequencer and successive approximation
  always @* begin
    state_nxt = state_r;
    pos_nxt   = pos_r;
    sar_nxt   = sar_r;
    dout_nxt  = result_serial_out;
    oe_nxt    = result_serial_oe;
    track_nxt = tracking;
    case (state_r)
      ST_IDLE: begin
        if (frame_start) begin
          state_nxt = ST_SHIFT;
          pos_nxt   = {`POS_W{1'b0}};
          sar_nxt   = {`CORE_BITS{1'b0}};
          dout_nxt  = 1'b0;
          oe_nxt    = 1'b1;
          track_nxt = 1'b0;
        end
      end
      ST_SHIFT: begin
        // Select rising mid-word aborts: release the line and track again
        if (cs_high) begin
          state_nxt = ST_IDLE;
          oe_nxt    = 1'b0;
          track_nxt = 1'b1;
        end else if (sclk_fall) begin
          pos_nxt = pos_r + 1'b1;
          if (pos_nxt == `POS_LAST) begin
            state_nxt = ST_DONE;
            oe_nxt    = 1'b0;
            dout_nxt  = 1'b0;
          end else if (pos_nxt >= `LEAD_ZEROS && pos_nxt < res_end) begin
            // One comparator decision per serial clock falling edge
            if (held_r >= (sar_r | trial_bit(res_index(pos_nxt)))) begin
              sar_nxt  = sar_r | trial_bit(res_index(pos_nxt));
              dout_nxt = 1'b1;
            end else begin
              dout_nxt = 1'b0;
            end
            if (pos_nxt == res_end - 1'b1) begin
              track_nxt = 1'b1;
            end
          end else begin
            dout_nxt = 1'b0;
          end
        end
      end
      ST_DONE: begin
        // Wait out the frame; the line stays released
        if (cs_high) begin
          state_nxt = ST_IDLE;
          track_nxt = 1'b1;
        end
      end
      default: begin
        // Illegal code: fall back to idle with the line released
        state_nxt = ST_IDLE;
        oe_nxt    = 1'b0;
        track_nxt = 1'b1;
      end
    endcase
  end

  // Frame control and pin registers
  always @(posedge core_clk) begin
    if (rst) begin
      state_r           <= ST_IDLE;
      pos_r             <= {`POS_W{1'b0}};
      result_serial_out <= 1'b0;
      result_serial_oe  <= `OE_RST;
      tracking          <= `TRACK_RST;
    end else begin
      state_r           <= state_nxt;
      pos_r             <= pos_nxt;
      result_serial_out <= dout_nxt;
      result_serial_oe  <= oe_nxt;
      tracking          <= track_nxt;
    end
  end

  // Approximation register and held sample; held keeps the last word if the buffer ran dry
  always @(posedge core_clk) begin
    if (rst) begin
      sar_r  <= {`CORE_BITS{1'b0}};
      held_r <= {`CORE_BITS{1'b0}};
    end else begin
      sar_r <= sar_nxt;
      if (frame_start && fifo_valid) begin
        held_r <= fifo_data;
      end
    end
  end

endmodule // serial_adc_readout_port

// ### dv/serial_adc_readout_port_properties.sv
`timescale 1ns/10ps
module serial_adc_readout_port_properties (
  // Clock and reset
  input wire        core_clk,
  input wire        rst,
  // Serial link pins
  input wire        sclk,
  input wire        cs_n,
  input wire        result_serial_out,
  input wire        result_serial_oe,
  // Sample side and status
  input wire [11:0] analog_in,
  input wire        analog_in_valid,
  input wire        analog_in_ready,
  input wire        tracking
);
  logic [4:0] falls_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Raw pin falls per frame; runs ahead of the synchronised copy
  always @(posedge core_clk) begin
    if (rst || cs_n) falls_r <= 5'h00;
    else if ($fell(sclk)) falls_r <= falls_r + 5'h01;
  end
  property p_start; $fell(cs_n) |-> ##[2:5] $rose(result_serial_oe); endproperty
  a_start: assert property (p_start) else $error("no drive after select");
  property p_lead; $rose(result_serial_oe) |-> !result_serial_out && !tracking; endproperty
  a_lead: assert property (p_lead) else $error("bad first bit");
  property p_stable; $rose(sclk) && !cs_n |-> ##2 $stable(result_serial_out)[*4]; endproperty
  a_stable: assert property (p_stable) else $error("data moved on rise");
  property p_idle; cs_n[*5] |-> !result_serial_oe && tracking; endproperty
  a_idle: assert property (p_idle) else $error("driven while idle");
  property p_abort; $rose(cs_n) |-> ##[2:5] !result_serial_oe; endproperty
  a_abort: assert property (p_abort) else $error("no release on deselect");
  property p_words; $fell(result_serial_oe) |-> cs_n || falls_r == 5'h10; endproperty
  a_words: assert property (p_words) else $error("short word");
  property p_track; $fell(result_serial_oe) |-> tracking; endproperty
  a_track: assert property (p_track) else $error("not tracking");
  property p_release; falls_r == 5'h10 && !cs_n |-> ##[2:6] !result_serial_oe; endproperty
  a_release: assert property (p_release) else $error("held after last bit");
endmodule // serial_adc_readout_port_properties

// ### dv/adc_ctrl_model.sv
`timescale 1ns/10ps
module adc_ctrl_model (
  // Clock
  input wire   core_clk,
  // One data line per variant, resolved
  input wire [2:0] sdo,
  // Controller pins
  output logic sclk,
  output logic cs_n
);
  logic [15:0] w [3];
  // Serial clock stands high outside frames
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
  end
  // Bits are taken just before each fall, where they have stood longest
  task frame(input int nf);
    cs_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    for (int i = 0; i < nf; i++) begin
      for (int j = 0; j < 3; j++) w[j] = {w[j][14:0], sdo[j]};
      sclk <= 1'b0;
      repeat (4) @(posedge core_clk);
      sclk <= 1'b1;
      repeat (4) @(posedge core_clk);
    end
  endtask
  // Deselect, then quiet time well above 50 ns
  task close;
    cs_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
endmodule // adc_ctrl_model

// ### dv/serial_adc_readout_port_tb.sv
`timescale 1ns/10ps
module serial_adc_readout_port_tb;
  logic        core_clk, rst, ain_valid;
  logic [11:0] ain;
  wire         sclk, cs_n;
  wire [2:0]   dout, oe, rdy, trk, sdo;
  int          errors, samples_checked;
  // Variants 12, 10 and 8 bits side by side on one controller
  for (genvar g = 0; g < 3; g++) begin : v
    serial_adc_readout_port #(.RES_BITS(12 - 2 * g)) dut (.core_clk(core_clk), .rst(rst),
      .sclk(sclk), .cs_n(cs_n), .result_serial_out(dout[g]), .result_serial_oe(oe[g]),
      .analog_in(ain), .analog_in_valid(ain_valid), .analog_in_ready(rdy[g]),
      .tracking(trk[g]));
    assign sdo[g] = oe[g] ? dout[g] : 1'bz;
  end
  adc_ctrl_model ctl (.core_clk(core_clk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Narrow variants zero the low bits of the sample
  function logic [15:0] exp_word(input int g, input logic [11:0] s);
    exp_word = {4'h0, s} & (16'hFFFF << (2 * g));
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] want);
    samples_checked++;
    if (got !== want) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task results;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task t_reset;
    chk({7'h00, oe, trk, rdy}, 16'h003F);
  endtask
  // Fill until refused, then drain one word per frame in order
  task t_fill_drain;
    for (int k = 0; k < 16; k++) begin
      ain <= 12'(12'hFFF - k * 12'h111);
      ain_valid <= 1'b1;
      @(posedge core_clk);
    end
    #1 chk({13'h0000, rdy}, 16'h0000);
    ain <= 12'h123;
    @(posedge core_clk);
    ain_valid <= 1'b0;
    for (int k = 0; k < 16; k++) begin
      ctl.frame(16);
      chk({10'h000, oe, trk}, 16'h0007);
      for (int g = 0; g < 3; g++) chk(ctl.w[g], exp_word(g, 12'(12'hFFF - k * 12'h111)));
      ctl.close();
    end
    chk({13'h0000, rdy}, 16'h0007);
  endtask
  // Deselect mid-word, then a full word reuses the held sample
  task t_abort;
    ain <= 12'h5A3;
    ain_valid <= 1'b1;
    @(posedge core_clk);
    ain_valid <= 1'b0;
    ctl.frame(5);
    ctl.close();
    repeat (2) @(posedge core_clk);
    chk({10'h000, oe, trk}, 16'h0007);
    ctl.frame(16);
    for (int g = 0; g < 3; g++) chk(ctl.w[g], exp_word(g, 12'h5A3));
    ctl.close();
  endtask
  initial begin
    rst = 1'b1;
    ain = 12'h000;
    ain_valid = 1'b0;
    errors = 0;
    samples_checked = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    t_reset;
    t_fill_drain;
    t_abort;
    results;
  end
  // Hang guard, about four times the expected run
  initial begin
    #400000;
    errors++;
    results;
  end
endmodule // serial_adc_readout_port_tb
bind serial_adc_readout_port serial_adc_readout_port_properties chk_i (.core_clk(core_clk),
  .rst(rst), .sclk(sclk), .cs_n(cs_n), .result_serial_out(result_serial_out),
  .result_serial_oe(result_serial_oe), .analog_in(analog_in),
  .analog_in_valid(analog_in_valid), .analog_in_ready(analog_in_ready), .tracking(tracking));
